// ==== design/rxsao_top.sv ====
// receive sync, data and alarm output stage with APB registers
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ns
module rxsao_top #(
	parameter int LOS_6312_CYC = rxsao_pkg::LOS_6312_CYC,
	parameter int TX_LOSS_CYC  = rxsao_pkg::TX_LOSS_CYC
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic [7:0]               paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire rxsao_pkg::rxsao_line_type line_in,
	input  wire logic                     tx_clock_in,
	output logic                          rx_clk_out,
	output rxsao_pkg::rxsao_pins_type     rx_pins,
	output rxsao_pkg::rxsao_pins_type     rx_pins_oe_n,
	output logic                          irq
);

	typedef struct packed {
		logic [7:0]                s1;
		logic [7:0]                s2;
		logic                      clk_prev;
		logic                      tx_prev;
		logic                      dwide_hold;
		logic [7:0]                zero_cnt;
		logic [15:0]               zero_tmr;
		logic [15:0]               tx_tmr;
		logic [4:0]                ctrl;
		logic [2:0]                int_sts;
		logic [2:0]                int_mask;
		logic                      pready;
		logic                      pslverr;
		logic [31:0]               prdata;
		logic                      rclk;
		rxsao_pkg::rxsao_pins_type pins;
		rxsao_pkg::rxsao_pins_type oe_n;
		logic                      irq;
	} rxsao_state_type;

	localparam logic [15:0] LOS_LIM = 16'(LOS_6312_CYC);
	localparam logic [15:0] TXL_LIM = 16'(TX_LOSS_CYC);

	rxsao_state_type          st_reg;
	rxsao_state_type          st_next;
	rxsao_pkg::rxsao_line_type ln;
	rxsao_pkg::rxsao_mode_type mode;
	rxsao_pkg::rxsao_pins_type pn;
	logic                     rise;
	logic                     t1;
	logic                     e1;
	logic                     float_mode;
	logic                     bsel;
	logic                     dwide;
	logic                     flpf;
	logic                     boundary;
	logic                     tx_lost;
	logic                     acc;
	logic                     wr;
	logic [2:0]               events;
	logic [2:0]               w1c;
	logic [7:0]               zeros_lim;
	logic [31:0]              rd;
	logic                     hit;

	// all next-state logic in one place
	always_comb begin
		st_next    = st_reg;
		ln         = rxsao_pkg::rxsao_line_type'(st_reg.s2[6:0]);
		mode       = rxsao_pkg::rxsao_mode_type'(
			st_reg.ctrl[rxsao_pkg::CTRL_MODE_LSB +: 2]);
		bsel       = st_reg.ctrl[rxsao_pkg::CTRL_BSEL_BIT];
		dwide      = st_reg.ctrl[rxsao_pkg::CTRL_DWIDE_BIT];
		flpf       = st_reg.ctrl[rxsao_pkg::CTRL_FLPF_BIT];
		t1         = (mode == rxsao_pkg::MODE_T1);
		e1         = (mode == rxsao_pkg::MODE_E1);
		// reserved code floats the pins like 6312k, safest choice
		float_mode = ~(t1 | e1);
		pn         = st_reg.pins;
		rise       = ln.clk & ~st_reg.clk_prev;
		boundary   = 1'b0;
		tx_lost    = 1'b0;
		acc        = psel & penable;
		wr         = 1'b0;
		events     = 3'h0;
		w1c        = 3'h0;
		zeros_lim  = rxsao_pkg::ZEROS_E1;
		rd         = 32'h0;
		hit        = 1'b1;

		// pins pass two flops; s1 is read only by s2
		st_next.s1       = {tx_clock_in, line_in};
		st_next.s2       = st_reg.s1;
		st_next.clk_prev = ln.clk;
		st_next.tx_prev  = st_reg.s2[7];

		// recovered clock goes out as a retimed copy
		st_next.rclk = ln.clk;

		// tx clock supervision: count pclk since last transition
		if (st_reg.s2[7] != st_reg.tx_prev) begin
			st_next.tx_tmr = 16'h0;
		end else if (st_reg.tx_tmr != TXL_LIM) begin
			st_next.tx_tmr = st_reg.tx_tmr + 16'h1;
		end
		tx_lost = (st_reg.tx_tmr == TXL_LIM);

		// 6312k zero timer runs on pclk while the line is low
		if (rise && ln.data) begin
			st_next.zero_tmr = 16'h0;
		end else if (!st_reg.pins.rx_nrz_data &&
			st_reg.zero_tmr != LOS_LIM) begin
			st_next.zero_tmr = st_reg.zero_tmr + 16'h1;
		end

		// outside the float-mode clear below, the pins move only at a recovered edge
		if (rise) begin
			pn.rx_nrz_data = ln.data;

			// frame or multiframe boundary as chosen
			boundary = bsel ? ln.mframe_start
			                : ln.frame_start;
			if (st_reg.dwide_hold) begin
				pn.rx_sync_pulse   = 1'b1;
				st_next.dwide_hold = 1'b0;
			end else begin
				pn.rx_sync_pulse   = boundary;
				st_next.dwide_hold = boundary & t1 & ~bsel &
					dwide & ln.sig_frame;
			end

			// consecutive zero count, saturating
			if (ln.data) begin
				st_next.zero_cnt = 8'h0;
			end else if (st_reg.zero_cnt != 8'hff) begin
				st_next.zero_cnt = st_reg.zero_cnt + 8'h1;
			end
			zeros_lim = t1 ? rxsao_pkg::ZEROS_T1
			               : rxsao_pkg::ZEROS_E1;
			if (float_mode) begin
				pn.rx_signal_loss =
					(st_next.zero_tmr == LOS_LIM);
			end else begin
				pn.rx_signal_loss =
					(st_next.zero_cnt >= zeros_lim);
			end

			// frame-loss pin carries search or tx clock loss
			pn.rx_frame_loss = flpf ? tx_lost
			                        : ln.searching;

			// blue alarm in T1 and AIS in E1 share one detector
			pn.rx_alarm_indication = ln.ais_det;
		end

		// forced low at once, not at the next edge, so a pin never
		// floats while its flop still holds a stale alarm
		if (float_mode) begin
			pn.rx_sync_pulse       = 1'b0;
			pn.rx_frame_loss       = 1'b0;
			pn.rx_alarm_indication = 1'b0;
		end
		st_next.pins = pn;

		// floated sync, frame-loss and alarm pins keep their flop low; nrz data floats unforced
		st_next.oe_n.rx_sync_pulse       = float_mode;
		st_next.oe_n.rx_nrz_data         = float_mode;
		st_next.oe_n.rx_frame_loss       = float_mode;
		st_next.oe_n.rx_alarm_indication = float_mode;
		st_next.oe_n.rx_signal_loss      = 1'b0;

		// any change of an alarm pin is an event
		events[rxsao_pkg::EV_FLOSS] =
			pn.rx_frame_loss ^ st_reg.pins.rx_frame_loss;
		events[rxsao_pkg::EV_SLOSS] =
			pn.rx_signal_loss ^ st_reg.pins.rx_signal_loss;
		events[rxsao_pkg::EV_AIS] =
			pn.rx_alarm_indication ^ st_reg.pins.rx_alarm_indication;

		// APB: one wait state, write lands on the pready edge
		st_next.pready  = acc & ~st_reg.pready;
		st_next.pslverr = 1'b0;
		wr              = acc & st_reg.pready & pwrite;
		unique case (paddr)
			rxsao_pkg::ADDR_CTRL: begin
				rd = {27'h0, st_reg.ctrl};
				if (wr) begin
					st_next.ctrl = pwdata[rxsao_pkg::CTRL_WIDTH-1:0];
				end
			end
			rxsao_pkg::ADDR_STATUS: begin
				rd = {29'h0, st_reg.pins.rx_alarm_indication,
					st_reg.pins.rx_signal_loss,
					st_reg.pins.rx_frame_loss};
			end
			rxsao_pkg::ADDR_INT_STS: begin
				rd = {29'h0, st_reg.int_sts};
				if (wr) begin
					w1c = pwdata[2:0];
				end
			end
			rxsao_pkg::ADDR_INT_MASK: begin
				rd = {29'h0, st_reg.int_mask};
				if (wr) begin
					st_next.int_mask = pwdata[2:0];
				end
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		if (acc && !st_reg.pready) begin
			st_next.prdata  = hit ? rd : 32'h0;
			st_next.pslverr = ~hit;
		end

		// a new event beats a clear in the same cycle
		st_next.int_sts = (st_reg.int_sts & ~w1c) | events;
		st_next.irq     = |(st_next.int_sts & st_next.int_mask);
	end

	// single state register, async reset to constants
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg          <= '0;
			st_reg.ctrl     <= rxsao_pkg::CTRL_RST;
			st_reg.int_sts  <= rxsao_pkg::EVT_RST;
			st_reg.int_mask <= rxsao_pkg::EVT_RST;
			st_reg.oe_n     <= '1;
			st_reg.oe_n.rx_signal_loss <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state flops
	assign prdata       = st_reg.prdata;
	assign pready       = st_reg.pready;
	assign pslverr      = st_reg.pslverr;
	assign rx_clk_out   = st_reg.rclk;
	assign rx_pins      = st_reg.pins;
	assign rx_pins_oe_n = st_reg.oe_n;
	assign irq          = st_reg.irq;

endmodule : rxsao_top

// ==== design/rxsao_pkg.sv ====
// constants and types of the receive sync and alarm output stage
package rxsao_pkg;
	localparam int           CLK_PERIOD_NS  = 10;
	localparam logic [7:0]   ADDR_CTRL      = 8'h00;
	localparam logic [7:0]   ADDR_STATUS    = 8'h04;
	localparam logic [7:0]   ADDR_INT_STS   = 8'h08;
	localparam logic [7:0]   ADDR_INT_MASK  = 8'h0c;
	localparam int           CTRL_MODE_LSB  = 0;
	localparam int           CTRL_BSEL_BIT  = 2;
	localparam int           CTRL_DWIDE_BIT = 3;
	localparam int           CTRL_FLPF_BIT  = 4;
	localparam int           CTRL_WIDTH     = 5;
	localparam logic [4:0]   CTRL_RST       = 5'h00;
	localparam logic [2:0]   EVT_RST        = 3'h0;
	localparam int           EV_FLOSS       = 0;
	localparam int           EV_SLOSS       = 1;
	localparam int           EV_AIS         = 2;
	localparam logic [7:0]   ZEROS_T1       = 8'hc0;
	localparam logic [7:0]   ZEROS_E1       = 8'hff;
	localparam int           SCALED_MCLK_NS = 488;
	localparam int           TX_LOSS_PER    = 15;
	localparam int           TX_LOSS_NS     = TX_LOSS_PER * SCALED_MCLK_NS;
	localparam int           TX_LOSS_CYC    = TX_LOSS_NS / CLK_PERIOD_NS;
	localparam int           LOS_6312_NS    = 65000;
	localparam int           LOS_6312_CYC   =
		(LOS_6312_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		MODE_T1    = 2'b00,
		MODE_E1    = 2'b01,
		MODE_S6312 = 2'b10,
		MODE_RSVD  = 2'b11
	} rxsao_mode_type;

	// signals arriving from the line recovery and framer
	typedef struct packed {
		logic clk;
		logic data;
		logic frame_start;
		logic mframe_start;
		logic sig_frame;
		logic searching;
		logic ais_det;
	} rxsao_line_type;

	// receive-side pins toward the system
	typedef struct packed {
		logic rx_sync_pulse;
		logic rx_nrz_data;
		logic rx_frame_loss;
		logic rx_signal_loss;
		logic rx_alarm_indication;
	} rxsao_pins_type;
endpackage : rxsao_pkg

// ==== verif/rxsao_asserts.sv ====
// checker for the receive output stage, bound to its top module
`timescale 1ns/1ns
module rxsao_asserts (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pready,
	input wire logic                      pslverr,
	input wire logic [31:0]               prdata,
	input wire rxsao_pkg::rxsao_line_type line_in,
	input wire logic                      rx_clk_out,
	input wire rxsao_pkg::rxsao_pins_type rx_pins,
	input wire rxsao_pkg::rxsao_pins_type rx_pins_oe_n
);
	logic [1:0] sync_cnt; // recovered edges seen under one sync pulse
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// saturating count, so a stuck pulse cannot wrap back to legal
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sync_cnt <= 2'h0;
		else if (!rx_pins.rx_sync_pulse)
			sync_cnt <= 2'h0;
		else if ($rose(rx_clk_out) && sync_cnt != 2'h3)
			sync_cnt <= sync_cnt + 2'h1;
	end
	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing after one wait state");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	chk_clk_follow: assert property (
		rx_clk_out == $past(line_in.clk, 3))
		else $error("recovered clock output off");
	chk_float_quiet: assert property (
		rx_pins_oe_n.rx_sync_pulse |-> !rx_pins.rx_sync_pulse &&
		!rx_pins.rx_frame_loss && !rx_pins.rx_alarm_indication)
		else $error("floated pins not quiet");
	chk_float_group: assert property (
		!rx_pins_oe_n.rx_signal_loss && !rx_pins_oe_n.rx_alarm_indication
		== !rx_pins_oe_n.rx_sync_pulse && rx_pins_oe_n[4:2] == {3{
		rx_pins_oe_n.rx_alarm_indication}})
		else $error("output enables inconsistent");
	chk_data_edge: assert property (
		$changed(rx_pins.rx_nrz_data) && !rx_pins_oe_n.rx_nrz_data &&
		!$past(rx_pins_oe_n.rx_nrz_data) |-> rx_clk_out &&
		!$past(rx_clk_out, 2))
		else $error("data moved off a recovered edge");
	chk_sync_width: assert property (sync_cnt != 2'h3)
		else $error("sync pulse too wide");
	chk_los_clear: assert property (
		rx_pins.rx_nrz_data |-> !rx_pins.rx_signal_loss)
		else $error("signal loss with a one received");
	chk_los_rise: assert property (
		$rose(rx_pins.rx_signal_loss) && !rx_pins_oe_n.rx_nrz_data
		|-> $rose(rx_clk_out))
		else $error("signal loss off a recovered edge");
	cover property ($rose(rx_pins.rx_signal_loss));
	cover property (sync_cnt == 2'h2);
	cover property (pslverr);
endmodule : rxsao_asserts
bind rxsao_top rxsao_asserts u_chk (
	.pclk        (pclk),
	.presetn     (presetn),
	.psel        (psel),
	.penable     (penable),
	.pready      (pready),
	.pslverr     (pslverr),
	.prdata      (prdata),
	.line_in     (line_in),
	.rx_clk_out  (rx_clk_out),
	.rx_pins     (rx_pins),
	.rx_pins_oe_n(rx_pins_oe_n)
);

// ==== verif/rxsao_sink.sv ====
// downstream consumer latching the receive pins on recovered edges
`timescale 1ns/1ns
module rxsao_sink (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic                      rx_clk_out,
	input wire rxsao_pkg::rxsao_pins_type rx_pins,
	output rxsao_pkg::rxsao_pins_type     seen,
	output int unsigned                   edges
);
	logic prev_clk; // last sampled recovered clock
	// pins move with the clock, so they are taken at its rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_clk <= 1'b0;
			seen <= '0;
			edges <= 0;
		end else begin
			prev_clk <= rx_clk_out;
			if (rx_clk_out && !prev_clk) begin
				seen <= rx_pins;
				edges <= edges + 1;
			end
		end
	end
endmodule : rxsao_sink

// ==== verif/rx_sync_alarm_outputs_tb.sv ====
// self-checking bench for the receive output stage
`timescale 1ns/1ns
module rx_sync_alarm_outputs_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, tx_clock_in = 1'b0, txon = 1'b1;
	logic pready, pslverr, ser, rx_clk_out, irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h9d5e;
	rxsao_pkg::rxsao_line_type line_in = '0;
	rxsao_pkg::rxsao_pins_type rx_pins, rx_pins_oe_n, seen;
	int unsigned edges, n_exp;
	logic [5:0] lv = 6'h0; // random line bit, frame boundaries kept apart
	int err_total = 0, cmp_count = 0, cyc = 0;
	rxsao_top #(.LOS_6312_CYC(40), .TX_LOSS_CYC(20)) i_dut (
		.pclk        (pclk),
		.presetn     (presetn),
		.paddr       (paddr),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.line_in     (line_in),
		.tx_clock_in (tx_clock_in),
		.rx_clk_out  (rx_clk_out),
		.rx_pins     (rx_pins),
		.rx_pins_oe_n(rx_pins_oe_n),
		.irq         (irq)
	);
	rxsao_sink i_sink (
		.pclk      (pclk),
		.presetn   (presetn),
		.rx_clk_out(rx_clk_out),
		.rx_pins   (rx_pins),
		.seen      (seen),
		.edges     (edges)
	);
	always #(rxsao_pkg::CLK_PERIOD_NS / 2) pclk = ~pclk;
	// tx clock toggles while enabled; the ceiling cuts a hang
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (txon)
			tx_clock_in <= ~tx_clock_in;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs
	function automatic int los_n(input int m);
		return m ? 255 : 192;
	endfunction : los_n
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// one transfer; idle edges after it let irq settle
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		ser = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : apb
	// one line bit, fields held 80 ns either side of the clock rise
	task lb(input logic [5:0] v);
		line_in <= {1'b0, v};
		repeat (8) @(posedge pclk);
		line_in.clk <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask : lb
	task print_verdict();
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	initial begin
		int m;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h10, 0);
		chk("unmapped err", 1, ser);
		chk("unmapped data", 0, rd);
		apb(0, rxsao_pkg::ADDR_CTRL, 0);
		chk("ctrl reset", 0, rd);
		chk("driven", 0, rx_pins_oe_n);
		apb(1, rxsao_pkg::ADDR_INT_MASK, 32'h2);
		for (m = 0; m < 2; m++) begin
			apb(1, rxsao_pkg::ADDR_CTRL, m);
			lb(6'h20);
			repeat (los_n(m) - 1) lb(6'h00);
			chk("loss early", 0, rx_pins.rx_signal_loss);
			lb(6'h00);
			chk("loss set", 1, rx_pins.rx_signal_loss);
			chk("irq set", 1, irq);
			apb(0, rxsao_pkg::ADDR_STATUS, 0);
			chk("status", 32'h2, rd);
			apb(0, rxsao_pkg::ADDR_INT_STS, 0);
			chk("int sts", 32'h2, rd);
			apb(1, rxsao_pkg::ADDR_INT_STS, 32'h7);
			chk("irq clear", 0, irq);
			lb(6'h20);
			chk("loss clear", 0, rx_pins.rx_signal_loss);
			apb(1, rxsao_pkg::ADDR_INT_STS, 32'h7);
			chk("irq idle", 0, irq);
		end
		apb(1, rxsao_pkg::ADDR_INT_MASK, 0);
		chk("irq masked", 0, irq);
		apb(1, rxsao_pkg::ADDR_CTRL, 32'h8);
		lb(6'h34);
		chk("sync first", 1, rx_pins.rx_sync_pulse);
		lb(6'h20);
		chk("sync second", 1, rx_pins.rx_sync_pulse);
		lb(6'h20);
		chk("sync end", 0, rx_pins.rx_sync_pulse);
		apb(1, rxsao_pkg::ADDR_CTRL, 32'h4);
		lb(6'h30);
		chk("mframe off", 0, rx_pins.rx_sync_pulse);
		lb(6'h29);
		chk("mframe on", 1, rx_pins.rx_sync_pulse);
		chk("blue", 1, rx_pins.rx_alarm_indication);
		apb(1, rxsao_pkg::ADDR_CTRL, 32'h10);
		lb(6'h22);
		chk("blue gone", 0, rx_pins.rx_alarm_indication);
		chk("tx ok", 0, rx_pins.rx_frame_loss);
		txon <= 1'b0;
		repeat (2) lb(6'h20);
		chk("tx lost", 1, rx_pins.rx_frame_loss);
		txon <= 1'b1;
		repeat (2) lb(6'h20);
		chk("tx back", 0, rx_pins.rx_frame_loss);
		apb(1, rxsao_pkg::ADDR_CTRL, 32'h1);
		n_exp = edges;
		repeat (48) begin
			seed = xs(seed);
			// real framing never puts boundaries on adjacent bits
			lv = {seed[5], seed[4] & ~lv[4], seed[3:0]};
			lb(lv);
			n_exp++;
			chk("data", lv[5], seen.rx_nrz_data);
			chk("sync", lv[4], rx_pins.rx_sync_pulse);
			chk("search", lv[1], rx_pins.rx_frame_loss);
			chk("ais", lv[0], rx_pins.rx_alarm_indication);
		end
		chk("edges", n_exp, edges);
		apb(1, rxsao_pkg::ADDR_CTRL, 32'h2);
		chk("float", 5'h1d, rx_pins_oe_n);
		repeat (4) lb(6'h13);
		chk("loss 6312", 1, rx_pins.rx_signal_loss);
		chk("quiet", 0, rx_pins[4] | rx_pins[2] | rx_pins[0]);
		apb(1, rxsao_pkg::ADDR_CTRL, 32'h3);
		chk("rsvd float", 5'h1d, rx_pins_oe_n);
		print_verdict();
	end
endmodule : rx_sync_alarm_outputs_tb
